//--- eirqp_core_model.sv
// Core-side model: software write path and the controls the core holds.
// Assumes the test sets the controls through ctl_wr, one edge ahead of use.
`timescale 1ns/10ps
module eirqp_core_model
  import eirqp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control values set by the test
  input wire logic ctl_wr,
  input wire logic [2:0] ctl_val,
  // Software write path
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  output logic [7:0] reg_wdata,
  // Controls held by the core
  output logic global_irq_enable,
  output logic cap_threshold_irq_level,
  output logic cap_done_irq_level
);
  logic [2:0] ctl_q;
  logic keep_low_six;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctl_q <= 3'h0;
    end else if (ctl_wr) begin
      ctl_q <= ctl_val;
    end
  end

  assign global_irq_enable = ctl_q[2];
  assign cap_threshold_irq_level = ctl_q[1];
  assign cap_done_irq_level = ctl_q[0];
  // Software never sets the top two bits of these two registers
  assign keep_low_six = (sw_addr == EIRQP_ADDR_MASK_ONE) || (sw_addr == EIRQP_ADDR_PRIO_ONE);
  assign reg_wdata = keep_low_six ? (sw_wdata & 8'h3F) : sw_wdata;
endmodule

//--- eirqp_gate.sv
// One interrupt source: global enable, own mask and own level bit.
// Assumes the pending flag comes from logic on the same clock.
`timescale 1ns/10ps
module eirqp_gate
  import eirqp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // Source and its controls
  input wire logic flag,
  input wire logic mask,
  input wire logic level,
  input wire logic global_en,
  // Registered requests
  output logic req_hi_q,
  output logic req_lo_q
);

  logic pass;
  logic req_hi_d;
  logic req_lo_d;

  // A flag passes only when both the global enable and the source mask are set
  assign pass = flag && mask && global_en;
  assign req_hi_d = pass && level;
  assign req_lo_d = pass && !level;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      req_hi_q <= 1'b0;
      req_lo_q <= 1'b0;
    end else if (ce) begin
      req_hi_q <= req_hi_d;
      req_lo_q <= req_lo_d;
    end
  end

endmodule

//--- eirqp_pkg.sv
// Package of constants for the extended interrupt mask and priority block.
// Assumes a single system clock and an 8-bit register port owned by the core.
package eirqp_pkg;

  // Register addresses on the core's register port
  localparam logic [7:0] EIRQP_ADDR_MASK_ONE = 8'hE6;
  localparam logic [7:0] EIRQP_ADDR_MASK_TWO = 8'hE7;
  localparam logic [7:0] EIRQP_ADDR_PRIO_ONE = 8'hF3;

  // Values after reset
  localparam logic [7:0] EIRQP_RST_MASK_ONE = 8'h00;
  localparam logic [7:0] EIRQP_RST_MASK_TWO = 8'h00;
  localparam logic [7:0] EIRQP_RST_PRIO_ONE = 8'h00;
  localparam logic [7:0] EIRQP_RST_RDATA = 8'h00;

  // Bits that hold state; all others are dropped on write and read as zero
  localparam logic [7:0] EIRQP_KEEP_MASK_ONE = 8'h3F;
  localparam logic [7:0] EIRQP_KEEP_MASK_TWO = 8'h03;
  localparam logic [7:0] EIRQP_KEEP_PRIO_ONE = 8'h3F;

  // Field positions in the first mask register
  localparam int EIRQP_M1_COMP = 5;
  localparam int EIRQP_M1_CONV = 4;
  localparam int EIRQP_M1_PCA = 3;
  localparam int EIRQP_M1_WIN = 2;
  localparam int EIRQP_M1_MATCH = 1;
  localparam int EIRQP_M1_TWOWIRE = 0;

  // Field positions in the second mask register
  localparam int EIRQP_M2_CAPTHR = 1;
  localparam int EIRQP_M2_CAPDONE = 0;

  // Field positions in the first priority register
  localparam int EIRQP_P1_COMP = 5;
  localparam int EIRQP_P1_PCA = 4;
  localparam int EIRQP_P1_CONV = 3;
  localparam int EIRQP_P1_WIN = 2;
  localparam int EIRQP_P1_MATCH = 1;
  localparam int EIRQP_P1_TWOWIRE = 0;

  // Source numbering on the request vectors; a lower number wins within a level
  localparam int EIRQP_NUM_SRC = 8;
  typedef enum logic [2:0] {
    EIRQP_SRC_TWOWIRE = 3'h0,
    EIRQP_SRC_MATCH = 3'h1,
    EIRQP_SRC_WIN = 3'h2,
    EIRQP_SRC_CONV = 3'h3,
    EIRQP_SRC_PCA = 3'h4,
    EIRQP_SRC_COMP = 3'h5,
    EIRQP_SRC_CAPDONE = 3'h6,
    EIRQP_SRC_CAPTHR = 3'h7
  } eirqp_src_t;

endpackage

//--- eirqp_top.sv
// Extended interrupt mask and priority registers with per-source gating.
// Assumes an 8-bit register port from the core and pending flags on mclk.
// Overview of operation
// - Bits 7 to 2 of the second mask register store nothing and always read as zero.
// - Mask-one bit 5 passes the comparator rise and fall flags when set and blocks both when clear.
// - Mask-one bit 4 passes the converter conversion-done flag when set and blocks it when clear.
// - Mask-one bit 3 passes every counter array source when set and blocks all when clear.
// - Mask-one bit 2 passes the converter window-compare flag when set and blocks it when clear.
// - Mask-one bit 1 passes port-match events when set and blocks them when clear.
// - Mask-one bit 0 passes the two-wire controller when set and blocks it when clear.
// - Mask-two bit 1 passes the capacitive threshold flag when set and blocks it when clear.
// - Mask-two bit 0 passes the capacitive done flag when set and blocks it when clear.
// - Priority-one bits 5..0 set the level of comparator, counter array, conversion, window, match, two-wire.
// - A priority bit of zero gives the low level and a one gives the high level.
// - With the global enable clear no source requests; with it set each follows its own mask.
`timescale 1ns/10ps
module eirqp_top
  import eirqp_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port from the core
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_hit_q,
  // Pending flags from the peripherals
  input wire logic comparator_rise_flag,
  input wire logic comparator_fall_flag,
  input wire logic conv_done_flag,
  input wire logic window_cmp_flag,
  input wire logic counter_array_flag,
  input wire logic port_match_flag,
  input wire logic twowire_flag,
  input wire logic cap_threshold_flag,
  input wire logic cap_done_flag,
  // Controls held elsewhere in the interrupt system
  input wire logic global_irq_enable,
  input wire logic cap_threshold_irq_level,
  input wire logic cap_done_irq_level,
  // Requests to the core's interrupt logic
  output logic [7:0] src_req_hi,
  output logic [7:0] src_req_lo,
  output logic irq_hi_q,
  output logic irq_lo_q,
  output logic [2:0] irq_hi_src_q,
  output logic [2:0] irq_lo_src_q
);

  logic [7:0] mask_one_q;
  logic [7:0] mask_one_d;
  logic [7:0] mask_two_q;
  logic [7:0] mask_two_d;
  logic [7:0] prio_one_q;
  logic [7:0] prio_one_d;
  logic [7:0] rdata_d;
  logic hit_d;
  logic irq_hi_d;
  logic irq_lo_d;
  logic [2:0] irq_hi_src_d;
  logic [2:0] irq_lo_src_d;
  logic [7:0] src_flag;
  logic [7:0] src_mask;
  logic [7:0] src_level;

  // Lowest set bit wins; a fixed order keeps arbitration within one level stable
  function automatic logic [3:0] pick_first(input logic [7:0] vec);
    logic [3:0] res;
    res = 4'h0;
    for (int i = EIRQP_NUM_SRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  // Address decode
  wire sel_mask_one = (reg_addr == EIRQP_ADDR_MASK_ONE);
  wire sel_mask_two = (reg_addr == EIRQP_ADDR_MASK_TWO);
  wire sel_prio_one = (reg_addr == EIRQP_ADDR_PRIO_ONE);
  wire sel_any = sel_mask_one || sel_mask_two || sel_prio_one;

  // Reserved bits are not stored, so a careless write cannot steer anything
  assign mask_one_d = (reg_wr && sel_mask_one) ? (reg_wdata & EIRQP_KEEP_MASK_ONE) : mask_one_q;
  assign mask_two_d = (reg_wr && sel_mask_two) ? (reg_wdata & EIRQP_KEEP_MASK_TWO) : mask_two_q;
  assign prio_one_d = (reg_wr && sel_prio_one) ? (reg_wdata & EIRQP_KEEP_PRIO_ONE) : prio_one_q;

  assign rdata_d = sel_mask_one ? mask_one_q :
                   sel_mask_two ? mask_two_q :
                   sel_prio_one ? prio_one_q : EIRQP_RST_RDATA;
  assign hit_d = reg_rd && sel_any;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mask_one_q <= EIRQP_RST_MASK_ONE;
      mask_two_q <= EIRQP_RST_MASK_TWO;
      prio_one_q <= EIRQP_RST_PRIO_ONE;
    end else if (ce) begin
      mask_one_q <= mask_one_d;
      mask_two_q <= mask_two_d;
      prio_one_q <= prio_one_d;
    end
  end

  // Read data is held until the next read so the core may sample late
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata_q <= EIRQP_RST_RDATA;
      reg_hit_q <= 1'b0;
    end else if (ce) begin
      reg_hit_q <= hit_d;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  // Source vectors; the comparator's two edges share one mask and one level
  assign src_flag = {cap_threshold_flag, cap_done_flag,
                     comparator_rise_flag || comparator_fall_flag,
                     counter_array_flag, conv_done_flag, window_cmp_flag,
                     port_match_flag, twowire_flag};
  assign src_mask = {mask_two_q[EIRQP_M2_CAPTHR],
                     mask_two_q[EIRQP_M2_CAPDONE],
                     mask_one_q[EIRQP_M1_COMP],
                     mask_one_q[EIRQP_M1_PCA],
                     mask_one_q[EIRQP_M1_CONV],
                     mask_one_q[EIRQP_M1_WIN],
                     mask_one_q[EIRQP_M1_MATCH],
                     mask_one_q[EIRQP_M1_TWOWIRE]};
  assign src_level = {cap_threshold_irq_level, cap_done_irq_level,
                      prio_one_q[EIRQP_P1_COMP], prio_one_q[EIRQP_P1_PCA],
                      prio_one_q[EIRQP_P1_CONV], prio_one_q[EIRQP_P1_WIN],
                      prio_one_q[EIRQP_P1_MATCH], prio_one_q[EIRQP_P1_TWOWIRE]};

  // One gate per source applies global enable, mask and level
  for (genvar g = 0; g < EIRQP_NUM_SRC; g++) begin : gen_src
    eirqp_gate u_gate (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .flag(src_flag[g]),
      .mask(src_mask[g]),
      .level(src_level[g]),
      .global_en(global_irq_enable),
      .req_hi_q(src_req_hi[g]),
      .req_lo_q(src_req_lo[g])
    );
  end

  // Winner per level; costs one extra cycle but keeps the outputs glitch free
  assign {irq_hi_d, irq_hi_src_d} = pick_first(src_req_hi);
  assign {irq_lo_d, irq_lo_src_d} = pick_first(src_req_lo);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_hi_q <= 1'b0;
      irq_lo_q <= 1'b0;
      irq_hi_src_q <= 3'h0;
      irq_lo_src_q <= 3'h0;
    end else if (ce) begin
      irq_hi_q <= irq_hi_d;
      irq_lo_q <= irq_lo_d;
      irq_hi_src_q <= irq_hi_src_d;
      irq_lo_src_q <= irq_lo_src_d;
    end
  end

  // Checks

  chk_mask_two_upper: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && reg_wr && sel_mask_two) |=> (mask_two_q[7:2] == 6'h00))
    else $error("second mask register stored an unused bit");

  chk_mask_two_read: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && reg_rd && sel_mask_two) |=> (reg_rdata_q[7:2] == 6'h00) && reg_hit_q)
    else $error("second mask register read back nonzero upper bits");

  chk_comp_pass: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[5] && (comparator_rise_flag || comparator_fall_flag))
      |=> (src_req_hi[5] || src_req_lo[5]))
    else $error("comparator request not passed");

  chk_comp_block: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && !mask_one_q[5]) |=> !(src_req_hi[5] || src_req_lo[5]))
    else $error("comparator request leaked through mask");

  chk_conv_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ce |=> ((src_req_hi[3] || src_req_lo[3]) ==
            $past(global_irq_enable && mask_one_q[4] && conv_done_flag)))
    else $error("conversion-done gating wrong");

  chk_pca_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ce |=> ((src_req_hi[4] || src_req_lo[4]) ==
            $past(global_irq_enable && mask_one_q[3] && counter_array_flag)))
    else $error("counter array gating wrong");

  chk_window_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ce |=> ((src_req_hi[2] || src_req_lo[2]) ==
            $past(global_irq_enable && mask_one_q[2] && window_cmp_flag)))
    else $error("window compare gating wrong");

  chk_match_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ce |=> ((src_req_hi[1] || src_req_lo[1]) ==
            $past(global_irq_enable && mask_one_q[1] && port_match_flag)))
    else $error("port match gating wrong");

  chk_twowire_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ce |=> ((src_req_hi[0] || src_req_lo[0]) ==
            $past(global_irq_enable && mask_one_q[0] && twowire_flag)))
    else $error("two-wire gating wrong");

  chk_capthr_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ce |=> ((src_req_hi[7] || src_req_lo[7]) ==
            $past(global_irq_enable && mask_two_q[1] && cap_threshold_flag)))
    else $error("capacitive threshold gating wrong");

  chk_capdone_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ce |=> ((src_req_hi[6] || src_req_lo[6]) ==
            $past(global_irq_enable && mask_two_q[0] && cap_done_flag)))
    else $error("capacitive done gating wrong");

  chk_pca_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[3] && counter_array_flag && prio_one_q[4])
      |=> src_req_hi[4] && !src_req_lo[4])
    else $error("counter array level taken from wrong priority bit");

  chk_conv_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[4] && conv_done_flag && prio_one_q[3])
      |=> src_req_hi[3] && !src_req_lo[3])
    else $error("conversion level taken from wrong priority bit");

  chk_low_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[5] && !prio_one_q[5] &&
     (comparator_rise_flag || comparator_fall_flag))
      |=> src_req_lo[5] && !src_req_hi[5])
    else $error("priority zero did not give low level");

  chk_global_off: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && !global_irq_enable) ##1 ce |=> !irq_hi_q && !irq_lo_q)
    else $error("request raised while global enable clear");

  chk_hi_winner: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && src_req_hi[0]) |=> irq_hi_q && (irq_hi_src_q == 3'h0))
    else $error("high level winner wrong");

  chk_lo_winner: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && src_req_lo[0]) |=> irq_lo_q && (irq_lo_src_q == 3'h0))
    else $error("low level winner wrong");

  chk_comp_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[5] && prio_one_q[5] &&
     (comparator_rise_flag || comparator_fall_flag))
      |=> src_req_hi[5] && !src_req_lo[5])
    else $error("comparator level taken from wrong priority bit");

  chk_win_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[2] && window_cmp_flag && prio_one_q[2])
      |=> src_req_hi[2] && !src_req_lo[2])
    else $error("window level taken from wrong priority bit");

  chk_match_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[1] && port_match_flag && prio_one_q[1])
      |=> src_req_hi[1] && !src_req_lo[1])
    else $error("port match level taken from wrong priority bit");

  chk_twowire_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_one_q[0] && twowire_flag && prio_one_q[0])
      |=> src_req_hi[0] && !src_req_lo[0])
    else $error("two-wire level taken from wrong priority bit");

  chk_capthr_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_two_q[1] && cap_threshold_flag)
      |=> (src_req_hi[7] == $past(cap_threshold_irq_level)) &&
          (src_req_lo[7] == !$past(cap_threshold_irq_level)))
    else $error("capacitive threshold level wrong");

  chk_capdone_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && global_irq_enable && mask_two_q[0] && cap_done_flag)
      |=> (src_req_hi[6] == $past(cap_done_irq_level)) &&
          (src_req_lo[6] == !$past(cap_done_irq_level)))
    else $error("capacitive done level wrong");

  chk_global_gate: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (ce && !global_irq_enable) |=> (src_req_hi == 8'h00) && (src_req_lo == 8'h00))
    else $error("source request raised while global enable clear");

endmodule

//--- test_extended_irq_enable_priority.sv
// Self-checking test of the extended interrupt mask and priority block.
// Assumes the package and the core-side model are compiled first.
`timescale 1ns/10ps
module test_extended_irq_enable_priority
  import eirqp_pkg::*;
;
  logic mclk, rst_b, ce, reg_wr, reg_rd, ctl_wr, reg_hit_q, irq_hi_q, irq_lo_q;
  logic glob, thr_lvl, done_lvl, g, m, l, hv, lv;
  logic [7:0] sw_addr, sw_wdata, reg_wdata, reg_rdata_q, src_req_hi, src_req_lo, e;
  logic [2:0] ctl_val, irq_hi_src_q, irq_lo_src_q;
  logic [8:0] fl;
  int failures, checks, s, c, idx;
  int mbit [6] = '{0, 1, 2, 4, 3, 5};

  eirqp_core_model eirqp_core_model_i (
    .mclk(mclk), .rst_b(rst_b), .ctl_wr(ctl_wr), .ctl_val(ctl_val), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .reg_wdata(reg_wdata), .global_irq_enable(glob),
    .cap_threshold_irq_level(thr_lvl), .cap_done_irq_level(done_lvl));

  eirqp_top eirqp_top_i (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_addr(sw_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q),
    .comparator_rise_flag(fl[5]), .comparator_fall_flag(fl[8]), .conv_done_flag(fl[3]),
    .window_cmp_flag(fl[2]), .counter_array_flag(fl[4]), .port_match_flag(fl[1]),
    .twowire_flag(fl[0]), .cap_threshold_flag(fl[7]), .cap_done_flag(fl[6]),
    .global_irq_enable(glob), .cap_threshold_irq_level(thr_lvl),
    .cap_done_irq_level(done_lvl), .src_req_hi(src_req_hi), .src_req_lo(src_req_lo),
    .irq_hi_q(irq_hi_q), .irq_lo_q(irq_lo_q), .irq_hi_src_q(irq_hi_src_q),
    .irq_lo_src_q(irq_lo_src_q));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    sw_addr = a;
    sw_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge mclk);
    #1;
    sw_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    chk("read data", reg_rdata_q, exp);
    chk("read hit", {7'h0, reg_hit_q}, {7'h0, hit});
  endtask

  task automatic setctl(input logic [2:0] v);
    @(posedge mclk);
    #1;
    ctl_val = v;
    ctl_wr = 1'b1;
    @(posedge mclk);
    #1;
    ctl_wr = 1'b0;
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctl_wr = 1'b0;
    ctl_val = 3'h0;
    sw_addr = 8'h00;
    sw_wdata = 8'h00;
    fl = 9'h000;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    rd(EIRQP_ADDR_MASK_ONE, 8'h00, 1'b1);
    rd(EIRQP_ADDR_MASK_TWO, 8'h00, 1'b1);
    rd(EIRQP_ADDR_PRIO_ONE, 8'h00, 1'b1);
    rd(8'hE8, 8'h00, 1'b0);
    wr(EIRQP_ADDR_MASK_ONE, 8'hFF);
    rd(EIRQP_ADDR_MASK_ONE, 8'h3F, 1'b1);
    wr(EIRQP_ADDR_MASK_TWO, 8'hFF);
    rd(EIRQP_ADDR_MASK_TWO, 8'h03, 1'b1);
    wr(EIRQP_ADDR_PRIO_ONE, 8'h2A);
    rd(EIRQP_ADDR_PRIO_ONE, 8'h2A, 1'b1);
    // A write while the clock enable is low must leave the register alone
    ce = 1'b0;
    wr(EIRQP_ADDR_PRIO_ONE, 8'h15);
    ce = 1'b1;
    rd(EIRQP_ADDR_PRIO_ONE, 8'h2A, 1'b1);
    $display("test registers done");
    // Every flag against each mix of global enable, mask and level
    for (s = 0; s < 9; s++) begin
      for (c = 0; c < 8; c++) begin
        idx = (s == 8) ? 5 : s;
        {g, m, l} = c[2:0];
        setctl({g, l, l});
        wr(EIRQP_ADDR_MASK_ONE, (idx < 6) ? (8'(m) << mbit[idx]) : 8'h00);
        wr(EIRQP_ADDR_PRIO_ONE, (idx < 6) ? (8'(l) << idx) : 8'h00);
        wr(EIRQP_ADDR_MASK_TWO, (idx >= 6) ? (8'(m) << (idx - 6)) : 8'h00);
        fl = 9'h001 << s;
        e = 8'(g & m) << idx;
        hv = g & m & l;
        lv = g & m & ~l;
        @(posedge mclk);
        #1;
        chk("high requests", src_req_hi, l ? e : 8'h00);
        chk("low requests", src_req_lo, l ? 8'h00 : e);
        @(posedge mclk);
        #1;
        chk("high summary", {4'h0, irq_hi_q, irq_hi_src_q}, {4'h0, hv, hv ? idx[2:0] : 3'h0});
        chk("low summary", {4'h0, irq_lo_q, irq_lo_src_q}, {4'h0, lv, lv ? idx[2:0] : 3'h0});
        fl = 9'h000;
      end
    end
    $display("test gating done");
    // Several sources at once: each keeps its own level and the lowest index wins
    setctl(3'h4);
    wr(EIRQP_ADDR_MASK_ONE, 8'h3F);
    wr(EIRQP_ADDR_PRIO_ONE, 8'h28);
    fl = 9'h038;
    @(posedge mclk);
    #1;
    chk("high requests", src_req_hi, 8'h28);
    chk("low requests", src_req_lo, 8'h10);
    @(posedge mclk);
    #1;
    chk("high summary", {4'h0, irq_hi_q, irq_hi_src_q}, 8'h0B);
    chk("low summary", {4'h0, irq_lo_q, irq_lo_src_q}, 8'h0C);
    fl = 9'h000;
    $display("test arbitration done");
    // A reset in mid-run must clear the first mask and priority registers again
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    rd(EIRQP_ADDR_MASK_ONE, 8'h00, 1'b1);
    rd(EIRQP_ADDR_PRIO_ONE, 8'h00, 1'b1);
    $display("test reset done");
    results();
  end

  // Tests need under eight hundred cycles; give them a wide margin
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule
